// File: ssdp_burst.sv
// constants of the data port and the burst address step
// assumes one clock; the counter value comes from the owner of the burst
//
// How it works
// - clock-qualify low: the edge counts and synchronous inputs are sampled
// - clock-qualify high: edges ignored, command pipeline and read data held; sleep sequencing, strap capture and output enable still act
// - sleep request high puts the memory into a retaining sleep
// - data lines as inputs are captured on the rising edge
// - reads drive the word addressed at the edge that began them
// - data and parity drive only while output enable is low
// - outputs float during write data, first cycle after deselect, deselected
// - parity lanes act like data, written only under their byte strobe
// - strap low gives linear burst order
// - strap high gives interleaved burst order
// - read data on the bus one edge after the command edge
// - interleaved address is start bits xor count 0 to 3
// - sleep entry and exit take two cycles; pending accesses dropped
`timescale 1ns/100ps

package ssdp_pkg;
  localparam int ADDR_W = 17;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int DATA_W = LANES * LANE_W;
  localparam int SLICE_W = LANE_W + 1;
  localparam int WORD_W = LANES * SLICE_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int BURST_W = 2;
  localparam logic [1:0] SLEEP_CYCLES = 2'h2;
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic MODE_LINEAR = 1'h0;
  typedef enum logic [3:0] {
    SL_AWAKE = 4'h1,
    SL_ENTER = 4'h2,
    SL_ASLEEP = 4'h4,
    SL_LEAVE = 4'h8
  } ssdp_sleep_type;
endpackage

module ssdp_burst (
  input wire logic [ssdp_pkg::BURST_W-1:0] start_i,
  input wire logic [ssdp_pkg::BURST_W-1:0] count_i,
  input wire logic interleaved_i,
  output logic [ssdp_pkg::BURST_W-1:0] addr_o
);
  import ssdp_pkg::*;
  always_comb begin
    if (interleaved_i) begin
      addr_o = start_i ^ count_i;
    end else begin
      addr_o = start_i + count_i;
    end
  end
endmodule

// File: ssdp_ctl_mdl.sv
// controller model driving command and data pins
// assumes op is called once per cycle
`timescale 1ns/100ps
module ssdp_ctl_mdl (
  input wire logic core_clk_i,
  output logic cq_n_o,
  output logic slp_o,
  output logic csa_n_o,
  output logic csb_o,
  output logic csc_n_o,
  output logic we_n_o,
  output logic ld_n_o,
  output logic oe_n_o,
  output logic [ssdp_pkg::ADDR_W-1:0] addr_o,
  output logic [ssdp_pkg::LANES-1:0] bw_n_o,
  output logic [ssdp_pkg::DATA_W-1:0] d_o,
  output logic [ssdp_pkg::LANES-1:0] p_o
);
  logic [36:0] q1 = '0;
  logic [36:0] q2 = '0;
  initial begin
    slp_o = 1'h0;
    cq_n_o = 1'h0;
    {ld_n_o, we_n_o, oe_n_o, csa_n_o, csb_o, csc_n_o} = 6'h3d;
    addr_o = '0;
    bw_n_o = 4'hf;
    {p_o, d_o} = '0;
  end
  task op(input logic ld, we, sl, input logic [16:0] a, input logic [3:0] bw,
    input logic oe, input logic [36:0] w);
    @(posedge core_clk_i);
    #1;
    {ld_n_o, we_n_o, oe_n_o, addr_o} = {ld, we, oe, a};
    {csa_n_o, csb_o, csc_n_o} = sl ? 3'h2 : 3'h5;
    bw_n_o = bw;
    if (q2[36]) {p_o, d_o} = q2[35:0];
    else {p_o, d_o} = ~{p_o, d_o};
    q2 = q1;
    q1 = w;
  endtask
endmodule

// File: ssdp_top.sv
// data port, clock qualify, sleep and burst order of the synchronous memory
// assumes command pins and output enable are timed by the same clock
`timescale 1ns/100ps

module ssdp_top (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic clock_qualify_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_mode_i,
  input wire logic [ssdp_pkg::ADDR_W-1:0] addr_i,
  input wire logic chip_select_a_n_i,
  input wire logic chip_select_b_i,
  input wire logic chip_select_c_n_i,
  input wire logic write_enable_n_i,
  input wire logic advance_or_load_n_i,
  input wire logic [ssdp_pkg::LANES-1:0] byte_write_strobe_n_i,
  input wire logic output_enable_n_i,
  input wire logic [ssdp_pkg::DATA_W-1:0] data_i,
  input wire logic [ssdp_pkg::LANES-1:0] parity_lines_i,
  output logic [ssdp_pkg::DATA_W-1:0] data_o,
  output logic [ssdp_pkg::LANES-1:0] parity_lines_o,
  output logic data_oe_o,
  output logic sleep_active_o
);
  import ssdp_pkg::*;

  // sleep request synchroniser
  logic sync1_ff, sync2_ff, sync3_ff, lvl_ff, nxt_lvl;
  ssdp_sleep_type sleep_ff, nxt_sleep;
  logic [1:0] slcnt_ff, nxt_slcnt;
  logic asleep_ff, nxt_asleep;

  // strap capture
  logic strap_done_ff, nxt_strap_done, interleaved_ff, nxt_interleaved;

  // command pipeline
  logic v1_ff, nxt_v1, wr1_ff, nxt_wr1, v2_ff, nxt_v2, wr2_ff, nxt_wr2;
  logic [ADDR_W-1:0] base_ff, nxt_base, addr2_ff, nxt_addr2;
  logic [BURST_W-1:0] cnt_ff, nxt_cnt, low_addr;
  logic [LANES-1:0] bw1_ff, nxt_bw1, bw2_ff, nxt_bw2;
  logic drive_ff, nxt_drive, oe_ff, nxt_oe;
  logic [ADDR_W-1:0] cur_addr;
  logic step, awake, sel;

  ssdp_burst u_burst (
    .start_i(base_ff[BURST_W-1:0]),
    .count_i(cnt_ff),
    .interleaved_i(interleaved_ff),
    .addr_o(low_addr)
  );

  assign cur_addr = {base_ff[ADDR_W-1:BURST_W], low_addr};
  assign awake = (sleep_ff == SL_AWAKE);
  assign step = ~clock_qualify_n_i & awake;
  assign sel = ~chip_select_a_n_i & chip_select_b_i & ~chip_select_c_n_i;

  // sleep sequencing
  always_comb begin
    nxt_lvl = lvl_ff;
    if (sync2_ff == sync3_ff) begin
      nxt_lvl = sync3_ff;
    end
    nxt_sleep = sleep_ff;
    nxt_slcnt = slcnt_ff;
    unique case (sleep_ff)
      SL_AWAKE: begin
        if (lvl_ff) begin
          nxt_sleep = SL_ENTER;
          nxt_slcnt = CNT_ONE;
        end
      end
      SL_ENTER: begin
        if (slcnt_ff == SLEEP_CYCLES) begin
          nxt_sleep = SL_ASLEEP;
        end else begin
          nxt_slcnt = slcnt_ff + CNT_ONE;
        end
      end
      SL_ASLEEP: begin
        if (!lvl_ff) begin
          nxt_sleep = SL_LEAVE;
          nxt_slcnt = CNT_ONE;
        end
      end
      SL_LEAVE: begin
        if (slcnt_ff == SLEEP_CYCLES) begin
          nxt_sleep = SL_AWAKE;
        end else begin
          nxt_slcnt = slcnt_ff + CNT_ONE;
        end
      end
      default: begin
        nxt_sleep = SL_AWAKE;
        nxt_slcnt = CNT_ZERO;
      end
    endcase
    nxt_asleep = (nxt_sleep != SL_AWAKE);
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_ff <= 1'h0;
      sync2_ff <= 1'h0;
      sync3_ff <= 1'h0;
      lvl_ff <= 1'h0;
      sleep_ff <= SL_AWAKE;
      slcnt_ff <= 2'h0;
      asleep_ff <= 1'h0;
    end else begin
      sync1_ff <= sleep_request_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      lvl_ff <= nxt_lvl;
      sleep_ff <= nxt_sleep;
      slcnt_ff <= nxt_slcnt;
      asleep_ff <= nxt_asleep;
    end
  end

  // strap taken once, on the first edge after reset
  always_comb begin
    nxt_strap_done = 1'h1;
    nxt_interleaved = interleaved_ff;
    if (!strap_done_ff) begin
      nxt_interleaved = (burst_mode_i != MODE_LINEAR);
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strap_done_ff <= 1'h0;
      interleaved_ff <= 1'h1;
    end else begin
      strap_done_ff <= nxt_strap_done;
      interleaved_ff <= nxt_interleaved;
    end
  end

  // command pipeline and output steering
  always_comb begin
    nxt_v1 = v1_ff;
    nxt_wr1 = wr1_ff;
    nxt_base = base_ff;
    nxt_cnt = cnt_ff;
    nxt_bw1 = bw1_ff;
    nxt_v2 = v2_ff;
    nxt_wr2 = wr2_ff;
    nxt_addr2 = addr2_ff;
    nxt_bw2 = bw2_ff;
    nxt_drive = drive_ff;
    if (!awake) begin
      nxt_v1 = 1'h0;
      nxt_v2 = 1'h0;
      nxt_drive = 1'h0;
    end else if (step) begin
      if (!advance_or_load_n_i) begin
        nxt_v1 = sel;
        nxt_wr1 = ~write_enable_n_i;
        nxt_base = addr_i;
        nxt_cnt = CNT_ZERO;
      end else begin
        nxt_cnt = cnt_ff + CNT_ONE;
      end
      nxt_bw1 = byte_write_strobe_n_i;
      nxt_v2 = v1_ff;
      nxt_wr2 = wr1_ff;
      nxt_addr2 = cur_addr;
      nxt_bw2 = bw1_ff;
      nxt_drive = v1_ff & ~wr1_ff;
    end
    nxt_oe = nxt_drive & ~output_enable_n_i;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      v1_ff <= 1'h0;
      wr1_ff <= 1'h0;
      base_ff <= '0;
      cnt_ff <= 2'h0;
      bw1_ff <= 4'hf;
      v2_ff <= 1'h0;
      wr2_ff <= 1'h0;
      addr2_ff <= '0;
      bw2_ff <= 4'hf;
      drive_ff <= 1'h0;
      oe_ff <= 1'h0;
    end else begin
      v1_ff <= nxt_v1;
      wr1_ff <= nxt_wr1;
      base_ff <= nxt_base;
      cnt_ff <= nxt_cnt;
      bw1_ff <= nxt_bw1;
      v2_ff <= nxt_v2;
      wr2_ff <= nxt_wr2;
      addr2_ff <= nxt_addr2;
      bw2_ff <= nxt_bw2;
      drive_ff <= nxt_drive;
      oe_ff <= nxt_oe;
    end
  end

  // per-lane storage, write port and read register
  for (genvar ln = 0; ln < LANES; ln++) begin : g_lane
    logic [SLICE_W-1:0] lane_mem [0:DEPTH-1];
    logic [SLICE_W-1:0] lane_rd_ff;
    always_ff @(posedge core_clk_i) begin
      if (step && v2_ff && wr2_ff && !bw2_ff[ln]) begin
        lane_mem[addr2_ff] <= {parity_lines_i[ln],
          data_i[ln*LANE_W +: LANE_W]};
      end
    end
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        lane_rd_ff <= '0;
      end else if (step && v1_ff && !wr1_ff) begin
        lane_rd_ff <= lane_mem[cur_addr];
      end
    end
    assign data_o[ln*LANE_W +: LANE_W] = lane_rd_ff[LANE_W-1:0];
    assign parity_lines_o[ln] = lane_rd_ff[LANE_W];
  end

  assign data_oe_o = oe_ff;
  assign sleep_active_o = asleep_ff;
endmodule

// File: ssdp_top_chk.sv
// assertions on the data port pins
// bound to ssdp_top from the bench
`timescale 1ns/100ps
module ssdp_top_chk (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic clock_qualify_n_i,
  input wire logic sleep_request_i,
  input wire logic chip_select_a_n_i,
  input wire logic chip_select_b_i,
  input wire logic chip_select_c_n_i,
  input wire logic write_enable_n_i,
  input wire logic advance_or_load_n_i,
  input wire logic output_enable_n_i,
  input wire logic [ssdp_pkg::DATA_W-1:0] data_o,
  input wire logic data_oe_o,
  input wire logic sleep_active_o
);
  import ssdp_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic go = !clock_qualify_n_i && !sleep_active_o;
  wire logic ld = go && !advance_or_load_n_i;
  wire logic sel = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i;
  a_oe_high_float: assert property (output_enable_n_i |=> !data_oe_o)
    else $error("drive while oe high");
  a_write_float: assert property (ld && sel && !write_enable_n_i ##1 go |=> !data_oe_o)
    else $error("drive in write data phase");
  a_desel_float: assert property (ld && !sel ##1 go |=> !data_oe_o)
    else $error("drive after deselect");
  a_read_drive: assert property (ld && sel && write_enable_n_i ##1 (go && !output_enable_n_i)
    |=> data_oe_o)
    else $error("read not driven");
  a_hold_data: assert property (clock_qualify_n_i |=> $stable(data_o))
    else $error("data moved while held");
  a_sleep_float: assert property (sleep_active_o |=> !data_oe_o)
    else $error("drive while asleep");
  a_sleep_entry: assert property ($rose(sleep_request_i) |-> ##[1:8] sleep_active_o)
    else $error("sleep not entered");
  a_sleep_exit: assert property ($fell(sleep_request_i) |-> ##[1:8] !sleep_active_o)
    else $error("sleep not left");
  cover property (ld && sel && write_enable_n_i);
  cover property (ld && sel && !write_enable_n_i);
  cover property (sleep_active_o);
  cover property (go && advance_or_load_n_i);
endmodule

// File: test_sync_sram_data_port_control.sv
// self-checking bench of the data port
// assumes ssdp_top and the model ssdp_ctl_mdl
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
  $display("Error at %0t: %h %h", $time, a, b); end end
module test_sync_sram_data_port_control;
  import ssdp_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic mode = 1'h1;
  int fail_count = 0;
  int n_compared = 0;
  logic [WORD_W-1:0] exp [8];
  wire logic cq_n, slp, csa_n, csb, csc_n, we_n, ld_n, oe_n, doe, sact;
  wire logic [ADDR_W-1:0] addr;
  wire logic [LANES-1:0] bw, p, dp;
  wire logic [DATA_W-1:0] d, dq;
  ssdp_ctl_mdl ssdp_ctl_mdl_i (.core_clk_i(clk), .cq_n_o(cq_n), .slp_o(slp), .csa_n_o(csa_n),
    .csb_o(csb), .csc_n_o(csc_n), .we_n_o(we_n), .ld_n_o(ld_n), .oe_n_o(oe_n), .addr_o(addr),
    .bw_n_o(bw), .d_o(d), .p_o(p));
  ssdp_top ssdp_top_i (.core_clk_i(clk), .arst_n_i(rst_n), .clock_qualify_n_i(cq_n),
    .sleep_request_i(slp), .burst_mode_i(mode), .addr_i(addr), .chip_select_a_n_i(csa_n),
    .chip_select_b_i(csb), .chip_select_c_n_i(csc_n), .write_enable_n_i(we_n),
    .advance_or_load_n_i(ld_n), .byte_write_strobe_n_i(bw), .output_enable_n_i(oe_n),
    .data_i(d), .parity_lines_i(p), .data_o(dq), .parity_lines_o(dp), .data_oe_o(doe),
    .sleep_active_o(sact));
  initial begin
    forever #25 clk = ~clk;
  end
  task conclude();
    $display("compared %0d, errors %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task reset(input logic m);
    #1 rst_n = 1'h0;
    mode = m;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'h1;
  endtask
  task nop(input logic oe);
    ssdp_ctl_mdl_i.op(1'h0, 1'h1, 1'h0, '0, 4'hf, oe, '0);
  endtask
  task wr(input logic [16:0] a, input logic [3:0] bw, input logic [35:0] v);
    for (int n = 0; n < LANES; n++) if (!bw[n]) begin
      exp[a[2:0]][8*n+:8] = v[8*n+:8];
      exp[a[2:0]][32+n] = v[32+n];
    end
    ssdp_ctl_mdl_i.op(1'h0, 1'h0, 1'h1, a, bw, 1'h0, {1'h1, v});
  endtask
  task rd(input logic [16:0] a, input logic oe);
    ssdp_ctl_mdl_i.op(1'h0, 1'h1, 1'h1, a, 4'hf, oe, '0);
    nop(oe);
    nop(oe);
    `CHK(doe, !oe)
    if (!oe) `CHK({dp, dq}, exp[a[2:0]])
  endtask
  task t_rw();
    for (int a = 4; a < 8; a++) wr(17'(a), 4'h0, {4'(a), 32'h7654_3210 ^ 32'(a)});
    nop(1'h0);
    nop(1'h0);
    for (int a = 4; a < 8; a++) rd(17'(a), 1'h0);
    rd(17'h5, 1'h1);
  endtask
  task t_byte();
    wr(17'h4, 4'he, 36'h0);
    nop(1'h0);
    nop(1'h0);
    rd(17'h4, 1'h0);
  endtask
  task t_hold();
    ssdp_ctl_mdl_i.op(1'h0, 1'h1, 1'h1, 17'h6, 4'hf, 1'h0, '0);
    nop(1'h0);
    ssdp_ctl_mdl_i.cq_n_o = 1'h1;
    repeat (3) @(posedge clk);
    #1 ssdp_ctl_mdl_i.cq_n_o = 1'h0;
    `CHK({doe, dp, dq}, {1'h0, exp[4]})
    nop(1'h0);
    `CHK({doe, dp, dq}, {1'h1, exp[6]})
  endtask
  task t_burst(input logic m);
    logic [1:0] c;
    reset(m);
    ssdp_ctl_mdl_i.op(1'h0, 1'h1, 1'h1, 17'h5, 4'hf, 1'h0, '0);
    for (int k = 0; k < 5; k++) begin
      ssdp_ctl_mdl_i.op(k > 2 ? 1'h0 : 1'h1, 1'h1, k < 3, 17'h5, 4'hf, 1'h0, '0);
      c = 2'(k - 1);
      if (k > 0) `CHK({dp, dq}, exp[m ? {1'h1, 2'h1 ^ c} : {1'h1, 2'h1 + c}])
    end
  endtask
  task t_sleep();
    nop(1'h0);
    ssdp_ctl_mdl_i.slp_o = 1'h1;
    repeat (10) nop(1'h0);
    `CHK({sact, doe}, 2'h2)
    ssdp_ctl_mdl_i.slp_o = 1'h0;
    repeat (10) nop(1'h0);
    `CHK(sact, 1'h0)
    rd(17'h7, 1'h0);
  endtask
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
  initial begin
    reset(1'h1);
    t_rw();
    t_byte();
    t_hold();
    t_burst(1'h1);
    t_burst(1'h0);
    t_sleep();
    conclude();
  end
endmodule
bind ssdp_top ssdp_top_chk ssdp_top_chk_i (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
  .clock_qualify_n_i(clock_qualify_n_i), .sleep_request_i(sleep_request_i),
  .chip_select_a_n_i(chip_select_a_n_i), .chip_select_b_i(chip_select_b_i),
  .chip_select_c_n_i(chip_select_c_n_i), .write_enable_n_i(write_enable_n_i),
  .advance_or_load_n_i(advance_or_load_n_i), .output_enable_n_i(output_enable_n_i),
  .data_o(data_o), .data_oe_o(data_oe_o), .sleep_active_o(sleep_active_o));
